// file: rtl/icm_pkg.sv
/*
 * constants, carriers and arithmetic helpers of the interval counter.
 * assumes a 32-bit apb slave wrapper and one 16-bit counter per instance.
 */

package icm_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] ICM_CTRL_OFF = 12'h000;
	localparam logic [11:0] ICM_COUNT_OFF = 12'h004;
	localparam logic [11:0] ICM_STATUS_OFF = 12'h008;
	localparam int ICM_BCD_POS = 0;
	localparam int ICM_MODE_LSB = 1;
	localparam int ICM_RW_LSB = 4;

	// ****************************************
	// encodings
	// ****************************************
	localparam logic [1:0] ICM_RW_LATCH = 2'h0;
	localparam logic [1:0] ICM_RW_LSB_ONLY = 2'h1;
	localparam logic [1:0] ICM_RW_MSB_ONLY = 2'h2;
	localparam logic [1:0] ICM_RW_BOTH = 2'h3;
	localparam logic [1:0] ICM_STEP_ONE = 2'h1;
	localparam logic [1:0] ICM_STEP_TWO = 2'h2;
	localparam logic [1:0] ICM_STEP_THREE = 2'h3;
	localparam logic [15:0] ICM_CNT_RST = 16'h0000;
	localparam logic [15:0] ICM_CNT_ONE = 16'h0001;
	localparam logic [7:0] ICM_BYTE_RST = 8'h00;

	typedef enum logic [2:0] {
		ICM_M_TERM = 3'h0,
		ICM_M_ONESHOT = 3'h1,
		ICM_M_RATE = 3'h2,
		ICM_M_SQUARE = 3'h3,
		ICM_M_SWSTB = 3'h4,
		ICM_M_HWSTB = 3'h5
	} icm_mode_type;

	typedef enum logic [0:0] {
		ICM_BYTE_LO = 1'b0,
		ICM_BYTE_HI = 1'b1
	} icm_byte_type;

	typedef struct packed {
		logic [1:0] rw;
		logic [2:0] mode;
		logic bcd;
	} icm_ctrl_type;

	typedef struct packed {
		logic out;
		logic pend;
		icm_ctrl_type ctrl;
	} icm_status_type;

	localparam icm_ctrl_type ICM_CTRL_RST = '{rw: 2'h1, mode: 3'h0, bcd: 1'b0};

	// ****************************************
	// helpers
	// ****************************************
	// modes 6 and 7 alias 2 and 3
	function automatic icm_mode_type icm_norm_mode(input logic [2:0] m);
		return m[1] ? icm_mode_type'({1'b0, m[1:0]}) : icm_mode_type'(m);
	endfunction

	function automatic logic [15:0] icm_bcd_dec1(input logic [15:0] v);
		logic [15:0] r;
		logic brw;
		r = v;
		brw = 1'b1;
		for (int k = 0; k < 4; k++) begin
			if (brw) begin
				if (r[k*4+:4] == 4'h0) begin
					r[k*4+:4] = 4'h9;
				end else begin
					r[k*4+:4] = r[k*4+:4] - 4'h1;
					brw = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// zero wraps to ffff or 9999, so zero acts as the largest count
	function automatic logic [15:0] icm_sub(input logic [15:0] v,
		input logic bcd, input logic [1:0] step);
		logic [15:0] r;
		r = v;
		for (int i = 0; i < 3; i++) begin
			if (2'(i) < step) begin
				r = bcd ? icm_bcd_dec1(r) : r - ICM_CNT_ONE;
			end
		end
		return r;
	endfunction

endpackage

// file: rtl/icm_pin_sync.sv
/*
 * two-flop synchronisers with edge pulses for the counter pins.
 * assumes the pins are asynchronous to pclk and much slower than it.
 */
`timescale 1ns/10ps
module icm_pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] pin_async,
	output logic [1:0] lvl,
	output logic [1:0] rise,
	output logic [1:0] fall
);
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] last_q;

	// ****************************************
	// synchroniser
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
			last_q <= 2'h0;
		end else begin
			meta_q <= pin_async;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign lvl = sync_q;
	assign rise = sync_q & ~last_q;
	assign fall = ~sync_q & last_q;
endmodule // icm_pin_sync

// file: rtl/icm_top.sv
/*
 * one 16-bit interval counter with six modes behind an apb slave.
 * assumes counter clock and gate pins far slower than pclk.
 */
`timescale 1ns/10ps
module icm_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cnt_clk_pin,
	input wire logic gate_pin,
	output logic out_pin
);
	logic [1:0] pin_lvl;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;
	logic tick;
	logic sample;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;

	// ****************************************
	// pin synchronisers
	// ****************************************
	icm_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_async({gate_pin, cnt_clk_pin}),
		.lvl(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign tick = pin_fall[0];
	assign sample = pin_rise[0];
	assign gate_lvl = pin_lvl[1];
	assign gate_rise = pin_rise[1];
	assign gate_fall = pin_fall[1];

	// ****************************************
	// apb decode
	// ****************************************
	logic access;
	logic addr_hit;
	logic wr;
	logic ctrl_wr;
	logic cnt_wr;
	logic first_byte;
	logic final_byte;
	logic [15:0] new_cnt;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	icm_pkg::icm_ctrl_type ctrl_q;
	icm_pkg::icm_ctrl_type ctrl_d;
	icm_pkg::icm_ctrl_type wr_ctrl;
	icm_pkg::icm_byte_type byte_q;
	icm_pkg::icm_byte_type byte_d;
	icm_pkg::icm_mode_type mode;
	icm_pkg::icm_status_type status;
	logic [7:0] lo_q;
	logic [7:0] lo_d;

	assign access = psel & penable;
	assign addr_hit = (paddr == icm_pkg::ICM_CTRL_OFF) |
		(paddr == icm_pkg::ICM_COUNT_OFF) |
		(paddr == icm_pkg::ICM_STATUS_OFF);
	// zero wait states: the read word is caught in the setup cycle
	assign pready = access;
	assign pslverr = access & ~addr_hit;
	assign prdata = prdata_q;
	assign wr = access & pwrite;
	assign wr_ctrl = icm_pkg::icm_ctrl_type'(pwdata[5:0]);
	// latch commands belong to other logic and are ignored here
	assign ctrl_wr = wr & (paddr == icm_pkg::ICM_CTRL_OFF) &
		(wr_ctrl.rw != icm_pkg::ICM_RW_LATCH);
	assign cnt_wr = wr & (paddr == icm_pkg::ICM_COUNT_OFF);
	assign first_byte = cnt_wr & (ctrl_q.rw == icm_pkg::ICM_RW_BOTH) &
		(byte_q == icm_pkg::ICM_BYTE_LO);
	assign final_byte = cnt_wr & ~first_byte;
	assign mode = icm_pkg::icm_norm_mode(ctrl_q.mode);

	always_comb begin
		case (ctrl_q.rw)
			icm_pkg::ICM_RW_LSB_ONLY: new_cnt = {8'h00, pwdata[7:0]};
			icm_pkg::ICM_RW_MSB_ONLY: new_cnt = {pwdata[7:0], 8'h00};
			default: new_cnt = {pwdata[7:0], lo_q};
		endcase
	end

	// ****************************************
	// counter state
	// ****************************************
	logic [15:0] cr_q;
	logic [15:0] cr_d;
	logic [15:0] ce_q;
	logic [15:0] ce_d;
	logic out_q;
	logic out_d;
	logic pend_q;
	logic pend_d;
	logic hold_q;
	logic hold_d;
	logic loaded_q;
	logic loaded_d;
	logic armed_q;
	logic armed_d;
	logic first_q;
	logic first_d;
	logic odd_q;
	logic odd_d;
	logic cr_ok_q;
	logic cr_ok_d;
	logic gate_q;
	logic gate_d;
	logic trig_flag_q;
	logic trig_flag_d;
	logic trig_q;
	logic trig_d;
	logic [1:0] step;
	logic [15:0] nxt;
	logic nxt_zero;

	assign status = '{out: out_q, pend: pend_q, ctrl: ctrl_q};

	always_comb begin
		if (mode == icm_pkg::ICM_M_SQUARE && first_q && odd_q) begin
			step = out_q ? icm_pkg::ICM_STEP_ONE :
				icm_pkg::ICM_STEP_THREE;
		end else if (mode == icm_pkg::ICM_M_SQUARE) begin
			step = icm_pkg::ICM_STEP_TWO;
		end else begin
			step = icm_pkg::ICM_STEP_ONE;
		end
		nxt = icm_pkg::icm_sub(ce_q, ctrl_q.bcd, step);
		nxt_zero = (nxt == icm_pkg::ICM_CNT_RST);
	end

	always_comb begin
		ctrl_d = ctrl_q;
		byte_d = byte_q;
		lo_d = lo_q;
		cr_d = cr_q;
		ce_d = ce_q;
		out_d = out_q;
		pend_d = pend_q;
		hold_d = hold_q;
		loaded_d = loaded_q;
		armed_d = armed_q;
		first_d = first_q;
		odd_d = odd_q;
		cr_ok_d = cr_ok_q;
		gate_d = gate_q;
		trig_flag_d = trig_flag_q;
		trig_d = trig_q;
		// gate sampled on the counter clock's rising edge
		if (sample) begin
			gate_d = gate_lvl;
			trig_d = trig_flag_q;
			trig_flag_d = 1'b0;
		end
		// an edge in the clearing cycle is kept
		if (gate_rise) begin
			trig_flag_d = 1'b1;
		end
		if (tick) begin
			trig_d = 1'b0;
			case (mode)
				icm_pkg::ICM_M_TERM,
				icm_pkg::ICM_M_SWSTB: begin
					if (mode == icm_pkg::ICM_M_SWSTB) begin
						out_d = 1'b1;
					end
					if (pend_q && !hold_q) begin
						ce_d = cr_q;
						pend_d = 1'b0;
						loaded_d = 1'b1;
						armed_d = 1'b1;
					end else if (loaded_q && gate_q && !hold_q) begin
						ce_d = nxt;
						if (nxt_zero && mode == icm_pkg::ICM_M_TERM) begin
							out_d = 1'b1;
						end
						if (nxt_zero && mode == icm_pkg::ICM_M_SWSTB) begin
							out_d = ~armed_q;
							armed_d = 1'b0;
						end
					end
				end
				icm_pkg::ICM_M_ONESHOT: begin
					if (trig_q && cr_ok_q) begin
						ce_d = cr_q;
						pend_d = 1'b0;
						out_d = 1'b0;
						loaded_d = 1'b1;
					end else if (loaded_q) begin
						ce_d = nxt;
						if (nxt_zero) begin
							out_d = 1'b1;
						end
					end
				end
				icm_pkg::ICM_M_HWSTB: begin
					out_d = 1'b1;
					if (trig_q && cr_ok_q) begin
						ce_d = cr_q;
						pend_d = 1'b0;
						armed_d = 1'b1;
						loaded_d = 1'b1;
					end else if (loaded_q) begin
						ce_d = nxt;
						if (nxt_zero) begin
							out_d = ~armed_q;
							armed_d = 1'b0;
						end
					end
				end
				icm_pkg::ICM_M_RATE: begin
					if ((pend_q && !loaded_q) || (trig_q && cr_ok_q)) begin
						ce_d = cr_q;
						pend_d = 1'b0;
						loaded_d = 1'b1;
						out_d = 1'b1;
					end else if (loaded_q && gate_q) begin
						if (ce_q == icm_pkg::ICM_CNT_ONE) begin
							ce_d = cr_q;
							pend_d = 1'b0;
							out_d = 1'b1;
						end else begin
							ce_d = nxt;
							out_d = (nxt != icm_pkg::ICM_CNT_ONE);
						end
					end
				end
				icm_pkg::ICM_M_SQUARE: begin
					if ((pend_q && !loaded_q) || (trig_q && cr_ok_q)) begin
						ce_d = cr_q;
						odd_d = cr_q[0];
						first_d = 1'b1;
						pend_d = 1'b0;
						loaded_d = 1'b1;
						out_d = 1'b1;
					end else if (loaded_q && gate_q) begin
						if (nxt_zero) begin
							ce_d = cr_q;
							odd_d = cr_q[0];
							first_d = 1'b1;
							pend_d = 1'b0;
							out_d = ~out_q;
						end else begin
							ce_d = nxt;
							first_d = 1'b0;
						end
					end
				end
				default: begin
					ce_d = ce_q;
				end
			endcase
		end
		// gate dropping in modes 2 and 3 lifts the output at once
		if (gate_fall && (mode == icm_pkg::ICM_M_RATE ||
			mode == icm_pkg::ICM_M_SQUARE)) begin
			out_d = 1'b1;
		end
		if (first_byte) begin
			lo_d = pwdata[7:0];
			byte_d = icm_pkg::ICM_BYTE_HI;
			if (mode == icm_pkg::ICM_M_TERM) begin
				hold_d = 1'b1;
				out_d = 1'b0;
			end
		end
		if (final_byte) begin
			cr_d = new_cnt;
			cr_ok_d = 1'b1;
			byte_d = icm_pkg::ICM_BYTE_LO;
			hold_d = 1'b0;
			pend_d = 1'b1;
			if (mode == icm_pkg::ICM_M_TERM) begin
				out_d = 1'b0;
			end
		end
		// control word beats everything and needs no counter clock
		if (ctrl_wr) begin
			ctrl_d = wr_ctrl;
			out_d = (icm_pkg::icm_norm_mode(wr_ctrl.mode) !=
				icm_pkg::ICM_M_TERM);
			pend_d = 1'b1;
			byte_d = icm_pkg::ICM_BYTE_LO;
			hold_d = 1'b0;
			loaded_d = 1'b0;
			armed_d = 1'b0;
			first_d = 1'b0;
			cr_ok_d = 1'b0;
			trig_flag_d = 1'b0;
			trig_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= icm_pkg::ICM_CTRL_RST;
			byte_q <= icm_pkg::ICM_BYTE_LO;
			lo_q <= icm_pkg::ICM_BYTE_RST;
			cr_q <= icm_pkg::ICM_CNT_RST;
			ce_q <= icm_pkg::ICM_CNT_RST;
			out_q <= 1'b0;
			pend_q <= 1'b0;
			hold_q <= 1'b0;
			loaded_q <= 1'b0;
			armed_q <= 1'b0;
			first_q <= 1'b0;
			odd_q <= 1'b0;
			cr_ok_q <= 1'b0;
			gate_q <= 1'b0;
			trig_flag_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			byte_q <= byte_d;
			lo_q <= lo_d;
			cr_q <= cr_d;
			ce_q <= ce_d;
			out_q <= out_d;
			pend_q <= pend_d;
			hold_q <= hold_d;
			loaded_q <= loaded_d;
			armed_q <= armed_d;
			first_q <= first_d;
			odd_q <= odd_d;
			cr_ok_q <= cr_ok_d;
			gate_q <= gate_d;
			trig_flag_q <= trig_flag_d;
			trig_q <= trig_d;
		end
	end

	assign out_pin = out_q;

	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				icm_pkg::ICM_CTRL_OFF: prdata_d = {26'h0, ctrl_q};
				icm_pkg::ICM_COUNT_OFF: prdata_d = {16'h0, cr_q};
				icm_pkg::ICM_STATUS_OFF: prdata_d = {ce_q, 8'h00, status};
				default: prdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else begin
			prdata_q <= prdata_d;
		end
	end
endmodule // icm_top

// file: tb/icm_properties.sv
/*
 * concurrent checks on the ports of the interval counter top.
 * assumes one pclk domain and an active-low async presetn.
 */
`timescale 1ns/10ps
module icm_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cnt_clk_pin,
	input wire logic gate_pin,
	input wire logic out_pin
);
	// ****************************************
	// helpers
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic acc;
	logic mapped;
	logic ctl_wr;
	assign acc = psel && penable;
	assign mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
	// latch commands (rw 00) leave the mode alone
	assign ctl_wr = acc && pwrite && paddr == 12'h000 && pwdata[5:4] != 2'h0;

	// ****************************************
	// properties
	// ****************************************
	AST_READY:
	assert property (pready == acc) else $error("pready wrong");
	AST_ERR_MAP:
	assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
	AST_ERR_OK:
	assert property (pslverr |-> acc && !mapped) else $error("stray pslverr");
	AST_RD_ZERO:
	assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped read data");
	AST_CTRL_LOW:
	assert property (ctl_wr && pwdata[3:1] == 3'h0 |=> ##[0:1] !out_pin)
		else $error("mode 0 out not low");
	AST_CTRL_HIGH:
	assert property (ctl_wr && pwdata[3:1] != 3'h0 |=> ##[0:1] out_pin)
		else $error("idle out not high");
	AST_QUIET:
	assert property (($stable(cnt_clk_pin) && $stable(gate_pin) && !psel) [*6]
		|=> $stable(out_pin)) else $error("out moved while quiet");
	AST_WR_DONE:
	assert property (acc |=> !pready || $changed(paddr) || psel)
		else $error("pready after release");
endmodule // icm_properties

// file: tb/icm_pin_drv.sv
/*
 * far-side model: counter clock and gate pin source.
 * assumes the pins are slow against pclk, 5 pclk high and 6 pclk low per counter clock.
 */
`timescale 1ns/10ps
module icm_pin_drv (
	input wire logic pclk,
	output logic cnt_clk_pin,
	output logic gate_pin
);
	initial begin
		cnt_clk_pin = 1'b0;
		gate_pin = 1'b1;
	end
	// clock stands low between bursts, so nothing counts unasked
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge pclk) cnt_clk_pin <= 1'b1;
			repeat (5) @(posedge pclk);
			cnt_clk_pin <= 1'b0;
			repeat (5) @(posedge pclk);
		end
		repeat (6) @(posedge pclk);
	endtask
	task automatic gate_to(input logic v);
		@(posedge pclk) gate_pin <= v;
		repeat (6) @(posedge pclk);
	endtask
endmodule // icm_pin_drv

// file: tb/interval_counter_modes_bench.sv
/*
 * self-checking bench for the interval counter over apb.
 * assumes icm_pin_drv as pin source; results read from status.
 */
`timescale 1ns/10ps
module interval_counter_modes_bench;
	logic pclk = 1'b0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cnt_clk_pin;
	logic gate_pin;
	logic out_pin;
	int err_count = 0;
	int checked = 0;
	int n;
	logic [63:0] q[$];
	logic [63:0] e;
	always #4 pclk = ~pclk;
	icm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cnt_clk_pin, .gate_pin,
		.out_pin);
	icm_pin_drv drv (.pclk, .cnt_clk_pin, .gate_pin);

	// ****************************************
	// apb tasks and scoreboard
	// ****************************************
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		// upper bits are noise the counter must ignore
		xfer(1'b1, a, {24'($urandom), d});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] v);
		q.push_back({m, v});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic so(input logic o);
		rd(icm_pkg::ICM_STATUS_OFF, 32'h80, {24'h0, o, 7'h0});
	endtask
	task automatic ce(input logic [15:0] v);
		rd(icm_pkg::ICM_STATUS_OFF, 32'hffff0000, {v, 16'h0});
	endtask
	task automatic pc(input int k, input logic o);
		drv.pulses(k);
		so(o);
	endtask
	task automatic cfg(input logic [7:0] c, input logic [7:0] v);
		wr(icm_pkg::ICM_CTRL_OFF, c);
		wr(icm_pkg::ICM_COUNT_OFF, v);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = q.size() > 0 ? q.pop_front() : {32'h0, 32'h1};
			checked++;
			if ((prdata & e[63:32]) !== e[31:0]) begin
				err_count++;
				$display("ERROR t=%0t got %h exp %h", $time,
					prdata & e[63:32], e[31:0]);
			end
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(32'hf4047b21));
		rd(icm_pkg::ICM_CTRL_OFF, 32'h3f, 32'h10);
		rd(12'h00c, 32'hffffffff, 32'h0);
		wr(icm_pkg::ICM_CTRL_OFF, 8'h06);
		rd(icm_pkg::ICM_CTRL_OFF, 32'h3f, 32'h10);
		$display("test reset done");
		cfg(8'h10, 8'h03);
		rd(icm_pkg::ICM_STATUS_OFF, 32'hc0, 32'h40);
		pc(1, 1'b0);
		ce(16'h3);
		pc(2, 1'b0);
		pc(1, 1'b1);
		pc(1, 1'b1);
		ce(16'hffff);
		drv.gate_to(1'b0);
		cfg(8'h10, 8'h02);
		pc(4, 1'b0);
		ce(16'h2);
		drv.gate_to(1'b1);
		pc(2, 1'b1);
		cfg(8'h30, 8'h01);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h00);
		pc(2, 1'b1);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h04);
		so(1'b0);
		drv.pulses(2);
		ce(16'h0);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h00);
		pc(4, 1'b0);
		pc(1, 1'b1);
		cfg(8'h11, 8'h00);
		drv.pulses(2);
		ce(16'h9999);
		$display("test mode 0 done");
		cfg(8'h12, 8'h03);
		pc(2, 1'b1);
		drv.gate_to(1'b0);
		drv.gate_to(1'b1);
		pc(1, 1'b0);
		pc(2, 1'b0);
		pc(1, 1'b1);
		drv.gate_to(1'b0);
		drv.gate_to(1'b1);
		pc(3, 1'b0);
		pc(1, 1'b1);
		drv.gate_to(1'b0);
		drv.gate_to(1'b1);
		pc(1, 1'b0);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h05);
		pc(2, 1'b0);
		pc(1, 1'b1);
		drv.gate_to(1'b0);
		drv.gate_to(1'b1);
		pc(5, 1'b0);
		pc(1, 1'b1);
		$display("test mode 1 done");
		cfg(8'h14, 8'h03);
		pc(2, 1'b1);
		pc(1, 1'b0);
		pc(1, 1'b1);
		pc(2, 1'b0);
		drv.gate_to(1'b0);
		so(1'b1);
		drv.gate_to(1'b1);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h04);
		pc(1, 1'b1);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h02);
		pc(2, 1'b1);
		pc(1, 1'b0);
		pc(1, 1'b1);
		pc(1, 1'b0);
		$display("test mode 2 done");
		repeat (3) begin
			n = 3 + $urandom % 6;
			cfg(8'h16, 8'(n));
			pc((n + 1) / 2, 1'b1);
			pc(1, 1'b0);
			pc(n / 2 - 1, 1'b0);
			pc(1, 1'b1);
		end
		$display("test mode 3 done");
		cfg(8'h18, 8'h02);
		pc(2, 1'b1);
		pc(1, 1'b0);
		pc(1, 1'b1);
		wr(icm_pkg::ICM_CTRL_OFF, 8'h38);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h03);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h00);
		pc(2, 1'b1);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h05);
		drv.pulses(1);
		ce(16'h1);
		wr(icm_pkg::ICM_COUNT_OFF, 8'h00);
		pc(5, 1'b1);
		pc(1, 1'b0);
		cfg(8'h1a, 8'h02);
		pc(3, 1'b1);
		drv.gate_to(1'b0);
		drv.gate_to(1'b1);
		pc(2, 1'b1);
		pc(1, 1'b0);
		pc(1, 1'b1);
		$display("test strobes done");
		complete_run();
	end
endmodule // interval_counter_modes_bench

bind icm_top icm_properties u_prop (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cnt_clk_pin,
	.gate_pin, .out_pin);
